/* rtl/tape_read_ext_status_port.sv */
// Host byte port: read data handshake and extended status dump
// What this block does
// [R01] Code E0 on the bus with the command handshake starts the status dump.
// [R02] Exactly 64 status bytes follow, each through its own handshake.
// [R03] Bytes 0 and 1 carry the two pointer and scratch registers.
// [R04] Byte 2 carries the last block address read from tape.
// [R05] Bytes 3 to 6: next host, active host, empty and full buffer flags.
// [R06] Buffer flag bytes use bits 5..3 only; mask equals 38 hex.
// [R07] Byte 7 bit 7: write channel told to use the rewrite buffer.
// [R08] Byte 7 bit 6: duplicate block being written after an overrun.
// [R09] Byte 7 bit 5: next host buffer flag holds a valid selection.
// [R10] Byte 7 bit 4: host channel transfer started and not finished.
// [R11] Byte 7 bit 3: next write buffer flag holds a valid selection.
// [R12] Byte 7 bit 2: write channel has begun a file mark.
// [R13] Per byte: data and ack, host strobe, ack drops, host strobe drops.
// [R14] After the last strobe release raise exception, then release the bus.
// [R15] On a command request drop ready, raise it 20 to 500 us later.
// [R16] Status bytes leave in ascending order, one per handshake.
// [R17] Drive the byte bus only while returning bytes.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "tape_port_defines.svh"
module tape_read_ext_status_port
   import tape_port_pkg::*;
#(
   parameter int ADDR_W = 9,
   parameter int READY_LOW = `READY_LOW_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [7:0] busIn,
   output logic [7:0] busOut,
   output logic busOe,
   input wire logic online,
   input wire logic request,
   input wire logic hostByteStrobe,
   output logic ready,
   output logic ack,
   output logic exception,
   output logic irq
);

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   generate
      if (READY_LOW < `READY_MIN_US * `CLK_MHZ || READY_LOW > `READY_MAX_US * `CLK_MHZ
          || READY_LOW >= (1 << `TIMER_W)) begin : g_bad_ready
         $error("READY_LOW outside the allowed ready low window");
      end
      if (ADDR_W != 9) begin : g_bad_addr
         $error("ADDR_W must be 9");
      end
   endgenerate

   localparam logic [`TIMER_W-1:0] TIMER_END = `TIMER_W'(READY_LOW - 1);

   // ----------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------
   logic [1:0] rstPipe;
   wire rstN = rstPipe[1];
   wire [10:0] pinSync;

   // Async assert, two-flop release
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) rstPipe <= 2'b00;
      else rstPipe <= {rstPipe[0], 1'b1};
   end

   pin_sync #(.WIDTH(11)) u_sync (
      .clk(clk),
      .rstN(rstN),
      .din({busIn, online, request, hostByteStrobe}),
      .dout(pinSync)
   );

   wire [7:0] busS = pinSync[10:3];
   wire onlineS = pinSync[2];
   wire requestS = pinSync[1];
   wire strobeS = pinSync[0];

   // ----------------------------------------
   // Software visible state
   // ----------------------------------------
   state_t state;
   state_t next_state;
   logic [7:0] cmd;
   logic [7:0] snap [0:7];
   logic [7:0] nxwtFlag;
   logic [7:0] rdByte;
   logic rdLast;
   logic rdPending;
   logic [`EV_BITS-1:0] irqStatus;
   logic [`EV_BITS-1:0] irqMask;
   logic [5:0] idx;
   logic [`TIMER_W-1:0] timer;
   logic xferActive;
   logic lastFlag;
   wire [7:0] memData;

   // ----------------------------------------
   // Bus write and read decode
   // ----------------------------------------
   wire wrGo = awvalid && wvalid && !awready && !bvalid;
   wire rdGo = arvalid && !arready && !rvalid;
   wire wLow = wrGo && wstrb[0];
   wire wSnapHit = awaddr[ADDR_W-1:5] == `A_SNAP_HI;
   wire wMemHit = awaddr[ADDR_W-1];
   wire wMask = awaddr == `A_IRQ_MASK;
   wire wRd = awaddr == `A_RDDATA;
   wire wNxwt = awaddr == `A_NXWT;
   wire wHit = wMask || wRd || wNxwt || wSnapHit || wMemHit
               || awaddr == `A_CMD || awaddr == `A_IRQ_STATUS || awaddr == `A_STATE;
   wire rSnapHit = araddr[ADDR_W-1:5] == `A_SNAP_HI;
   wire rMemHit = araddr[ADDR_W-1];
   wire rStat = araddr == `A_IRQ_STATUS;
   wire rHit = rSnapHit || rMemHit || rStat || araddr == `A_CMD
               || araddr == `A_IRQ_MASK || araddr == `A_STATE
               || araddr == `A_RDDATA || araddr == `A_NXWT;

   // ----------------------------------------
   // Status byte views
   // ----------------------------------------
   wire [7:0] view [0:7];
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_view
         if (g >= `IDX_NEXT_HOST && g <= `IDX_BUF_FULL) begin : g_buf
            // [R06] flag bits masked
            assign view[g] = snap[g] & `ALL_BUFFERS_MASK;
         end else if (g == `IDX_WFLAGS) begin : g_wf
            // [R07] [R08] [R09] [R10] [R11] [R12] write flags
            assign view[g] = {snap[g][7:6],
                              |(snap[`IDX_NEXT_HOST] & `ALL_BUFFERS_MASK),
                              xferActive,
                              |(nxwtFlag & `ALL_BUFFERS_MASK),
                              snap[g][2:0]};
         end else begin : g_plain
            assign view[g] = snap[g];
         end
      end
   endgenerate

   // Register read word
   wire [31:0] readWord =
      rSnapHit ? {24'h000000, view[araddr[4:2]]} :
      araddr == `A_CMD ? {24'h000000, cmd} :
      rStat ? {{(32 - `EV_BITS){1'b0}}, irqStatus} :
      araddr == `A_IRQ_MASK ? {{(32 - `EV_BITS){1'b0}}, irqMask} :
      araddr == `A_STATE ? {21'h000000, xferActive, idx, 1'b0, state} :
      araddr == `A_RDDATA ? {23'h000000, rdPending, rdByte} :
      araddr == `A_NXWT ? {24'h000000, nxwtFlag & `ALL_BUFFERS_MASK} :
      32'h00000000;

   // ----------------------------------------
   // Status memory for bytes beyond the snapshot
   // ----------------------------------------
   status_mem #(.WIDTH(8), .DEPTH(64), .AW(6)) u_mem (
      .clk(clk),
      .rstN(rstN),
      .wrEn(wLow && wMemHit),
      .wrAddr(awaddr[7:2]),
      .wrData(wdata[7:0]),
      .rdAddr(idx),
      .rdData(memData)
   );

   // ----------------------------------------
   // Byte port sequencer
   // ----------------------------------------
   logic next_ready;
   logic next_ack;
   logic next_exc;
   logic next_oe;
   logic next_host_byte_strobe;
   logic next_last;
   logic [7:0] next_busOut;
   logic [7:0] next_cmd;
   logic [5:0] next_idx;
   logic [`TIMER_W-1:0] next_timer;
   logic consume;
   logic [`EV_BITS-1:0] events;
   wire extCmd = cmd == `CMD_EXT_STATUS;
   wire isLast = extCmd ? (idx == `STATUS_LAST) : lastFlag;

   always_comb begin
      next_state = state;
      next_ready = ready;
      next_ack = ack;
      next_exc = exception;
      next_oe = busOe;
      next_host_byte_strobe = xferActive;
      next_last = lastFlag;
      next_busOut = busOut;
      next_cmd = cmd;
      next_idx = idx;
      next_timer = timer;
      consume = 1'b0;
      events = '0;
      case (state)
         S_IDLE: begin
            if (onlineS && requestS) begin
               // [R15] ready drops on request
               next_cmd = busS;
               next_ready = 1'b0;
               next_timer = '0;
               events[`EV_CMD] = 1'b1;
               next_state = S_DELAY;
            end
         end
         S_DELAY: begin
            next_timer = timer + 1'b1;
            if (timer == TIMER_END) begin
               // [R15] ready back after the low time
               next_ready = 1'b1;
               next_state = S_REQ_REL;
            end
         end
         S_REQ_REL: begin
            if (!requestS) begin
               // [R01] decode the dump command
               if (extCmd || cmd == `CMD_READ_DATA) begin
                  // [R17] bus turns toward the host
                  next_oe = 1'b1;
                  next_host_byte_strobe = 1'b1;
                  next_idx = '0;
                  next_state = S_FETCH;
               end else begin
                  next_state = S_IDLE;
               end
            end
         end
         S_FETCH: begin
            if (extCmd) begin
               next_state = S_LOAD;
            end else if (rdPending) begin
               // [R13] software byte with ack
               next_busOut = rdByte;
               next_last = rdLast;
               next_ack = 1'b1;
               consume = 1'b1;
               events[`EV_BYTE] = 1'b1;
               next_state = S_PRESENT;
            end
         end
         S_LOAD: begin
            // [R03] [R04] [R05] snapshot or stack byte
            next_busOut = (idx[5:3] == 3'h0) ? view[idx[2:0]] : memData;
            next_ack = 1'b1;
            next_state = S_PRESENT;
         end
         S_PRESENT: begin
            if (strobeS) begin
               // [R13] strobe seen, ack drops
               next_ack = 1'b0;
               next_state = S_TAKEN;
            end
         end
         S_TAKEN: begin
            if (!strobeS) begin
               if (isLast) begin
                  // [R14] exception after last release
                  next_exc = 1'b1;
                  next_host_byte_strobe = 1'b0;
                  events[`EV_DONE] = 1'b1;
                  next_state = S_DONE;
               end else begin
                  // [R02] [R16] next byte in order
                  next_idx = idx + 1'b1;
                  next_state = S_FETCH;
               end
            end
         end
         S_DONE: begin
            // [R14] bus back to host
            next_oe = 1'b0;
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
      // Online loss ends any command, also the normal exit from done
      if (!onlineS && state != S_IDLE) begin
         next_state = S_IDLE;
         next_ready = 1'b1;
         next_ack = 1'b0;
         next_exc = 1'b0;
         next_oe = 1'b0;
         next_host_byte_strobe = 1'b0;
      end
   end

   // Sequencer registers
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state <= S_IDLE;
         ready <= 1'b1;
         ack <= 1'b0;
         exception <= 1'b0;
         busOe <= 1'b0;
         xferActive <= 1'b0;
         lastFlag <= 1'b0;
         busOut <= 8'h00;
         cmd <= 8'h00;
         idx <= 6'h00;
         timer <= '0;
      end else begin
         state <= next_state;
         ready <= next_ready;
         ack <= next_ack;
         exception <= next_exc;
         busOe <= next_oe;
         xferActive <= next_host_byte_strobe;
         lastFlag <= next_last;
         busOut <= next_busOut;
         cmd <= next_cmd;
         idx <= next_idx;
         timer <= next_timer;
      end
   end

   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   // Snapshot bytes and flag registers; stack bytes live in memory
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         for (int i = 0; i < 8; i++) snap[i] <= 8'h00;
         nxwtFlag <= 8'h00;
         irqMask <= '0;
      end else if (wLow) begin
         if (wSnapHit) snap[awaddr[4:2]] <= wdata[7:0];
         if (wNxwt) nxwtFlag <= wdata[7:0];
         if (wMask) irqMask <= wdata[`EV_BITS-1:0];
      end
   end

   // Read data byte; a new write wins over a same-cycle consume
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rdByte <= 8'h00;
         rdLast <= 1'b0;
         rdPending <= 1'b0;
      end else if (wLow && wRd) begin
         rdByte <= wdata[7:0];
         rdLast <= wdata[`RD_LAST_BIT];
         rdPending <= 1'b1;
      end else if (consume) begin
         rdPending <= 1'b0;
      end
   end

   // Sticky events, read clears, set wins over clear
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         irqStatus <= '0;
         irq <= 1'b0;
      end else begin
         irqStatus <= (irqStatus & ~((arready && rStat) ? irqStatus : '0)) | events;
         irq <= |(irqStatus & irqMask);
      end
   end

   // ----------------------------------------
   // AXI4-Lite handshakes
   // ----------------------------------------
   // Address and data are taken together in one cycle
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else begin
         awready <= wrGo;
         wready <= wrGo;
         if (awready) begin
            bvalid <= 1'b1;
            bresp <= wHit ? `RESP_OKAY : `RESP_DECERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Read answer after the address handshake
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `RESP_OKAY;
      end else begin
         arready <= rdGo;
         if (arready) begin
            rvalid <= 1'b1;
            rdata <= readWord;
            rresp <= rHit ? `RESP_OKAY : `RESP_DECERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

endmodule // tape_read_ext_status_port

/* include/tape_port_defines.svh */
// Constants of the tape read and extended status byte port
`ifndef TAPE_PORT_DEFINES_SVH
`define TAPE_PORT_DEFINES_SVH

// Command codes on the byte bus
`define CMD_EXT_STATUS 8'hE0
`define CMD_READ_DATA 8'h80

// Extended status dump layout
`define STATUS_LAST 6'h3F
`define IDX_NEXT_HOST 3
`define IDX_BUF_FULL 6
`define IDX_WFLAGS 7
`define ALL_BUFFERS_MASK 8'h38

// Write flag byte bit positions
`define WF_HOST_VALID 5
`define WF_HOST_BUSY 4
`define WF_NXWT_VALID 3

// Ready low time after a command request
`define CLK_MHZ 100
`define READY_MIN_US 20
`define READY_MAX_US 500
`define READY_LOW_CYCLES (`READY_MIN_US * `CLK_MHZ)
`define TIMER_W 12

// Register byte addresses, snapshot window high address bits and read data last bit
`define A_CMD 9'h000
`define A_IRQ_STATUS 9'h004
`define A_IRQ_MASK 9'h008
`define A_STATE 9'h00C
`define A_RDDATA 9'h010
`define A_NXWT 9'h014
`define A_SNAP_HI 4'h1
`define RD_LAST_BIT 8

// Interrupt event bits
`define EV_CMD 0
`define EV_BYTE 1
`define EV_DONE 2
`define EV_BITS 3

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

/* include/tape_port_pkg.sv */
// Types shared by the tape byte port design
package tape_port_pkg;

   // Byte port sequencer states
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_DELAY = 3'b001,
      S_REQ_REL = 3'b010,
      S_FETCH = 3'b011,
      S_LOAD = 3'b100,
      S_PRESENT = 3'b101,
      S_TAKEN = 3'b110,
      S_DONE = 3'b111
   } state_t;

endpackage

/* rtl/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   // ----------------------------------------
   // Per-bit stages
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         // Output follows only once stages two and three agree
         always_ff @(posedge clk or negedge rstN) begin
            if (!rstN) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
               dout[g] <= 1'b0;
            end else begin
               s1 <= din[g];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3) dout[g] <= s3;
            end
         end
      end
   endgenerate

endmodule // pin_sync

/* rtl/status_mem.sv */
// Status byte memory with registered read port
`timescale 1ns/1ps
module status_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 64,
   parameter int AW = 6
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   input wire logic [AW-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData
);

   // Address width must cover the depth exactly
   generate
      if (DEPTH != (1 << AW)) begin : g_bad
         $error("status_mem depth does not match address width");
      end
   endgenerate

   logic [WIDTH-1:0] mem [0:DEPTH-1];

   // Array write, no reset on storage
   always_ff @(posedge clk) begin
      if (wrEn) mem[wrAddr] <= wrData;
   end

   // Registered read data
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) rdData <= '0;
      else rdData <= mem[rdAddr];
   end

endmodule // status_mem

/* tb/tape_port_checker_sva.sv */
// Assertions on the tape byte port pins and register bus
`timescale 1ns/1ps
module tape_port_checker #(
   parameter int READY_LOW = 2000
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic awvalid,
   input wire logic wvalid,
   input wire logic awready,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [7:0] busOut,
   input wire logic busOe,
   input wire logic online,
   input wire logic request,
   input wire logic hostByteStrobe,
   input wire logic ready,
   input wire logic ack,
   input wire logic exception
);
   // Ready low time, counted: too long to repeat
   logic [15:0] lowCnt;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lowCnt <= 16'h0000;
      end else begin
         lowCnt <= ready ? 16'h0000 : lowCnt + 16'h0001;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ----------------------------------------
   // Byte handshake steps
   // ----------------------------------------
   sequence s_byte_taken;
      ack ##0 hostByteStrobe;
   endsequence
   sequence s_exc_raised;
      !exception ##1 exception;
   endsequence
   AST_ACK_DROP: assert property (s_byte_taken |-> ##[1:8] !ack)
      else $error("ack held after host strobe");
   AST_BYTE_STABLE: assert property (ack && $past(ack) |-> $stable(busOut))
      else $error("byte changed while ack high");
   AST_ACK_DRIVES: assert property (ack |-> busOe)
      else $error("ack without bus drive");
   AST_EXC_NO_ACK: assert property (exception |-> !ack)
      else $error("ack during exception");
   AST_BUS_RELEASE: assert property (s_exc_raised |=> !busOe)
      else $error("bus kept after exception");
   AST_EXC_HOLD: assert property (exception && online |=> exception)
      else $error("exception dropped while online");
   AST_READY_SPACING: assert property ($rose(ready) |-> lowCnt >= READY_LOW && lowCnt <= 50000)
      else $error("ready low time out of range");
   AST_READY_DROP: assert property ($rose(request) && online && ready && !busOe |-> ##[1:8] !ready)
      else $error("ready did not drop on request");
   // Write answered next cycle
   AST_WR_ANSWER: assert property (awvalid && wvalid && !awready && !bvalid |=> awready && wready ##1 bvalid)
      else $error("write not answered");
   // Read answered next cycle
   AST_RD_ANSWER: assert property (arvalid && !arready && !rvalid |=> arready ##1 rvalid)
      else $error("read not answered");
   // Read data stands until taken
   AST_RVALID_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data not held");
endmodule // tape_port_checker

bind tape_read_ext_status_port tape_port_checker #(.READY_LOW(READY_LOW)) i_tape_port_checker (
   .clk(clk), .arst_n(arst_n), .awvalid(awvalid), .wvalid(wvalid), .awready(awready),
   .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
   .rready(rready), .rdata(rdata), .busOut(busOut), .busOe(busOe), .online(online),
   .request(request), .hostByteStrobe(hostByteStrobe), .ready(ready), .ack(ack),
   .exception(exception));

/* tb/host_model.sv */
// Host CPU model for the byte bus handshake
`timescale 1ns/1ps
module host_model (
   input wire logic clk,
   input wire logic [7:0] busOut,
   input wire logic busOe,
   input wire logic ready,
   input wire logic ack,
   input wire logic exception,
   output logic [7:0] busIn,
   output logic online,
   output logic request,
   output logic hostByteStrobe
);
   logic hostOe = 1'b0;
   logic [7:0] hostData = 8'h00;
   logic [7:0] got [0:63];
   int gotCount = 0;
   initial begin
      online = 1'b0;
      request = 1'b0;
      hostByteStrobe = 1'b0;
   end
   // Wire level; nobody driving shows a flipped byte, not a stale one
   assign busIn = busOe ? busOut : (hostOe ? hostData : ~busOut);
   // One command, then bytes until exception or a long silence
   task automatic run_cmd(input logic [7:0] code, input int slowDly);
      int n;
      gotCount = 0;
      online <= 1'b1;
      hostOe <= 1'b1;
      hostData <= code;
      @(posedge clk);
      request <= 1'b1;
      while (ready !== 1'b0) @(posedge clk);
      while (ready !== 1'b1) @(posedge clk);
      request <= 1'b0;
      hostOe <= 1'b0;
      n = 0;
      while (exception !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
         if (ack === 1'b1) begin
            if (gotCount < 64) got[gotCount] = busOut;
            gotCount++;
            repeat (slowDly) @(posedge clk);
            hostByteStrobe <= 1'b1;
            while (ack !== 1'b0) @(posedge clk);
            hostByteStrobe <= 1'b0;
            n = 0;
         end
      end
      online <= 1'b0;
      while (exception !== 1'b0) @(posedge clk);
      repeat (4) @(posedge clk);
   endtask
endmodule // host_model

/* tb/test_tape_read_ext_status_port.sv */
// Self-checking bench of the tape byte port
`timescale 1ns/1ps
`include "tape_port_defines.svh"
module test_tape_read_ext_status_port;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [8:0] awaddr = 9'h000, araddr = 9'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, busOe, ready, ack, exception, irq;
   logic [1:0] bresp, rresp;
   logic [7:0] busIn, busOut;
   logic online, request, hostByteStrobe;
   logic [7:0] img [0:63];
   logic [7:0] nxwt;
   logic [31:0] rnd = 32'hC06B09BC;
   int nErrors = 0;
   int checkCount = 0;
   int cycles = 0;
   always #5 clk = ~clk;
   tape_read_ext_status_port i_tape_read_ext_status_port (
      .clk(clk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .busIn(busIn), .busOut(busOut), .busOe(busOe), .online(online), .request(request),
      .hostByteStrobe(hostByteStrobe), .ready(ready), .ack(ack), .exception(exception),
      .irq(irq));
   host_model i_host_model (
      .clk(clk), .busOut(busOut), .busOe(busOe), .ready(ready), .ack(ack),
      .exception(exception), .busIn(busIn), .online(online), .request(request),
      .hostByteStrobe(hostByteStrobe));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Dumped view of a status byte; bit 4 of byte 7 is set mid-transfer
   function automatic logic [7:0] expByte(input int i);
      logic [7:0] b;
      b = img[i];
      if (i >= 3 && i <= 6) b = b & `ALL_BUFFERS_MASK;
      if (i == 7) b = {b[7:6], |(img[3] & 8'h38), 1'b1, |(nxwt & 8'h38), b[2:0]};
      return b;
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checkCount++;
      if (got !== exp) begin
         nErrors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic closeOut();
      $display("Comparisons %0d, mismatches %0d", checkCount, nErrors);
      if (nErrors == 0 && checkCount > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic axiWrite(input logic [8:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(posedge clk);
      while (awready !== 1'b1) @(posedge clk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      while (bvalid !== 1'b1) @(posedge clk);
      bready <= 1'b0;
      check("bresp", {30'h0, er}, {30'h0, bresp});
   endtask
   task automatic readCheck(input logic [8:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge clk);
      while (arready !== 1'b1) @(posedge clk);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clk);
      rready <= 1'b0;
      check("rdata", exp, rdata);
      check("rresp", {30'h0, er}, {30'h0, rresp});
   endtask
   task automatic runDump(input int slowDly);
      i_host_model.run_cmd(`CMD_EXT_STATUS, slowDly);
      check("byte count", 64, i_host_model.gotCount);
      for (int i = 0; i < 64; i++) begin
         check("status byte", {24'h0, expByte(i)}, {24'h0, i_host_model.got[i]});
      end
   endtask
   // Hang guard; about 10500 cycles are expected
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         nErrors++;
         closeOut();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check("idle pins", 32'h10, {27'h0, ready, ack, exception, busOe, irq});
      axiWrite(`A_IRQ_MASK, 32'h0, `RESP_OKAY);
      for (int i = 0; i < 64; i++) begin
         rnd = lfsr(rnd);
         img[i] = rnd[7:0];
         axiWrite(i < 8 ? 9'h020 + 9'(4 * i) : 9'h100 + 9'(4 * i), {24'h0, img[i]}, `RESP_OKAY);
      end
      rnd = lfsr(rnd);
      nxwt = rnd[7:0];
      axiWrite(`A_NXWT, {24'h0, nxwt}, `RESP_OKAY);
      wstrb <= 4'hE;
      axiWrite(`A_NXWT, 32'h0, `RESP_OKAY);
      wstrb <= 4'hF;
      readCheck(`A_NXWT, {24'h0, nxwt & `ALL_BUFFERS_MASK}, `RESP_OKAY);
      readCheck(9'h0FC, 32'h0, `RESP_DECERR);
      axiWrite(9'h0FC, 32'h1, `RESP_DECERR);
      $display("Test registers done");
      runDump(0);
      check("irq masked", 0, {31'h0, irq});
      axiWrite(`A_IRQ_MASK, 32'h7, `RESP_OKAY);
      repeat (2) @(posedge clk);
      check("irq raised", 1, {31'h0, irq});
      readCheck(`A_IRQ_STATUS, 32'h5, `RESP_OKAY);
      readCheck(`A_IRQ_STATUS, 32'h0, `RESP_OKAY);
      check("irq cleared", 0, {31'h0, irq});
      $display("Test random dump done");
      // No valid buffer bits: both valid flags of byte 7 must clear
      img[3] = 8'hC7;
      img[7] = 8'hFF;
      nxwt = 8'hC7;
      axiWrite(9'h02C, 32'hC7, `RESP_OKAY);
      axiWrite(9'h03C, 32'hFF, `RESP_OKAY);
      axiWrite(`A_NXWT, 32'hC7, `RESP_OKAY);
      runDump(2);
      $display("Test slow corner dump done");
      i_host_model.run_cmd(8'h55, 0);
      check("refused bytes", 0, i_host_model.gotCount);
      readCheck(`A_CMD, 32'h55, `RESP_OKAY);
      readCheck(`A_IRQ_STATUS, 32'h5, `RESP_OKAY);
      $display("Test refused code done");
      axiWrite(`A_RDDATA, 32'h1A5, `RESP_OKAY);
      i_host_model.run_cmd(`CMD_READ_DATA, 1);
      check("read bytes", 1, i_host_model.gotCount);
      check("read byte", 32'hA5, {24'h0, i_host_model.got[0]});
      readCheck(`A_IRQ_STATUS, 32'h7, `RESP_OKAY);
      $display("Test read data done");
      closeOut();
   end
endmodule // test_tape_read_ext_status_port
